// [nvm_loader_cfg.svh]
/*
 * Constants for the nonvolatile protect and bootstrap loader block.
 * Assumes a 100 MHz clock and byte-wide memory ports.
 */
`ifndef NVM_LOADER_CFG_SVH
`define NVM_LOADER_CFG_SVH
`define OPT_OFFSET          16'h0100
`define OPT_PROTECT_BIT     1
`define OPT_SECURE_BIT      0
`define CTRL_OFFSET         16'h0007
`define CTRL_LATCH_BIT      1
`define CTRL_ERASE_BIT      2
`define CTRL_PUMP_BIT       0
`define LOWER_REGION_BYTES  32
`define EE_BYTES            256
`define EE_BASE             16'h0100
`define CLK_MHZ             100
`define ERASE_TIME_MS       100
`define PROG_TIME_MS        5
`define BLINK_HALF_MS       167
`define MS_CYCLES(ms)       ((ms) * 1000 * `CLK_MHZ)
`define BOOT_HOLD_CYCLES    2
`endif

// [nvm_loader_pkg.sv]
/*
 * Types shared by the loader block.
 * Assumes the constants header is included by the design.
 */
package nvm_loader_pkg;
    // Bootstrap mode chosen once the entry pins have held past the reset release.
    typedef enum logic [5:0] {
        MODE_NONE    = 6'h01,
        MODE_CHECK   = 6'h02,
        MODE_PARPROG = 6'h04,
        MODE_SERIAL  = 6'h08,
        MODE_RAMLOAD = 6'h10,
        MODE_SERBOOT = 6'h20
    } boot_mode_e;

    // Mode select pins as sampled together.
    typedef struct packed {
        logic pin4;
        logic pin3;
        logic pin2;
        logic pin1;
    } mode_pins_s;

    // Address presented on the parallel loader pins.
    typedef struct packed {
        logic       comp2;
        logic [4:0] portc;
        logic [7:0] portb;
    } load_addr_s;
endpackage

// [nvm_loader.sv]
/*
 * Options bits, bootstrap mode selection, erased check and parallel
 * EPROM/EEPROM loader sequencer.
 * Assumes the memory arrays sit outside and answer reads in one cycle.
 */
// Our own choice: strobed register access.
// Behaviour
// - lower 32 bytes never protected, upper 224 may be
// - protect bit 0 blocks upper writes
// - erased protect keeps protection until reset
// - protect clears only while latch enable set
// - protection off in bootstrap mode
// - options bits survive every reset
// - secure bit 0 refuses ram and serial load
// - secure change takes effect after reset
// - bootstrap needs high-voltage irq and capture held
// - pin4 low picks check, program, serial
// - pin4 high picks ram or serial load
// - copy code then raise compare output one
// - red on nonzero byte, green when erased
// - wait pin1, erase eeprom, recheck until erased
// - clear secure bit once both erased
// - pin2 low gives 5 ms programming
// - ascending order, eight eprom bytes or one eeprom byte per pulse
// - data on port A, 14-bit address out
// - handshake lines a and b, tie disables
// - green blinks about 3 Hz while programming
// - verify against source, green or red
// - latch off forces erase and pump off
`timescale 1ns/1ns
`include "nvm_loader_cfg.svh"
module nvm_loader import nvm_loader_pkg::*; #(
    parameter int ERASE_CYCLES = `MS_CYCLES(`ERASE_TIME_MS),
    parameter int PROG_CYCLES  = `MS_CYCLES(`PROG_TIME_MS),
    parameter int BLINK_CYCLES = `MS_CYCLES(`BLINK_HALF_MS),
    parameter int EPROM_LO     = 16'h0300,
    parameter int EPROM_HI     = 16'h3dff
) (
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        nrst,
    // Register port.
    input  wire logic [15:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Bootstrap entry pins.
    input  wire logic        irq_high_volt,
    input  wire logic        capture_input_one,
    input  wire logic [3:0]  mode_pins,
    // Memory array access from the sequencer side.
    output logic      [15:0] mem_addr,
    output logic      [7:0]  mem_wdata,
    output logic             mem_wr,
    output logic             mem_erase,
    input  wire logic [7:0]  mem_rdata,
    // Array write permission toward the eeprom.
    input  wire logic [15:0] cpu_ee_addr,
    output logic             ee_write_allowed,
    // Parallel loader pins.
    input  wire logic [7:0]  port_a,
    output load_addr_s       load_addr,
    output logic             handshake_line_a,
    input  wire logic        handshake_line_b,
    // Status pins.
    output logic             compare_output_one,
    output logic             led_red,
    output logic             led_green,
    output logic             nonuser_allowed,
    output boot_mode_e       boot_mode
);
    if (PROG_CYCLES < 8 || ERASE_CYCLES < 1 || BLINK_CYCLES < 1) begin : g_bad_timing
        $error("Timing counts are too short.");
    end

    // Sequencer states.
    typedef enum logic [11:0] {
        S_IDLE   = 12'h001,
        S_COPY   = 12'h002,
        S_CHECK  = 12'h004,
        S_WAIT1  = 12'h008,
        S_ERASE  = 12'h010,
        S_ECHK   = 12'h020,
        S_CLRSEC = 12'h040,
        S_REQ    = 12'h080,
        S_PROG   = 12'h100,
        S_VREQ   = 12'h200,
        S_DONE   = 12'h400,
        S_FAIL   = 12'h800
    } seq_e;

    // Two-flop synchronisers for the pins.
    logic [6:0] pin_meta_reg, pin_sync_reg;
    logic [7:0] porta_meta_reg, porta_sync_reg;
    always_ff @(posedge clk) begin
        pin_meta_reg   <= {handshake_line_b, irq_high_volt, capture_input_one, mode_pins};
        pin_sync_reg   <= pin_meta_reg;
        porta_meta_reg <= port_a;
        porta_sync_reg <= porta_meta_reg;
    end
    logic       ack_s;
    mode_pins_s mp;
    assign ack_s = pin_sync_reg[6];
    assign mp    = pin_sync_reg[3:0];

    // Options cells: no reset touches them, so they start erased.
    logic       protect_cell_reg = 1'b1;
    logic       secure_cell_reg  = 1'b1;
    logic       secure_eff_reg, protect_eff_reg;   // Values in force since reset.
    logic       latch_reg, erase_reg, pump_reg;    // Eeprom control bits.
    logic       clr_secure;                        // Sequencer clears secure.

    // Decode of register addresses, used by read and write paths.
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        return a == off;
    endfunction

    // Options cell writes; reset leaves them alone.
    always_ff @(posedge clk) begin
        if (clr_secure) begin
            secure_cell_reg <= 1'b0;
        end else if (wr && hit(addr, `OPT_OFFSET)) begin
            secure_cell_reg <= wdata[`OPT_SECURE_BIT];
        end
        if (wr && hit(addr, `OPT_OFFSET)) begin
            if (wdata[`OPT_PROTECT_BIT]) begin
                protect_cell_reg <= 1'b1;
            end else if (latch_reg) begin
                protect_cell_reg <= 1'b0;
            end
        end
    end

    // Effective copies load only at reset, so changes wait for the next one.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            secure_eff_reg  <= secure_cell_reg;
            protect_eff_reg <= protect_cell_reg;
        end
    end

    // Eeprom control bits; latch off forces erase and pump off.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            latch_reg <= 1'b0;
            erase_reg <= 1'b0;
            pump_reg  <= 1'b0;
        end else if (wr && hit(addr, `CTRL_OFFSET)) begin
            latch_reg <= wdata[`CTRL_LATCH_BIT];
            erase_reg <= wdata[`CTRL_LATCH_BIT] & wdata[`CTRL_ERASE_BIT];
            pump_reg  <= wdata[`CTRL_LATCH_BIT] & wdata[`CTRL_PUMP_BIT];
        end
    end

    // Read data one cycle after the strobe; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= 8'h00;
        end else if (rd && hit(addr, `OPT_OFFSET)) begin
            rdata <= {6'h00, protect_cell_reg, secure_cell_reg};
        end else if (rd && hit(addr, `CTRL_OFFSET)) begin
            rdata <= {5'h00, erase_reg, latch_reg, pump_reg};
        end else begin
            rdata <= 8'h00;
        end
    end

    // Boot entry: pins held through the release and two cycles beyond.
    logic [1:0] hold_cnt_reg;
    logic       boot_ok_reg, boot_done_reg;
    logic       entry_ok;
    assign entry_ok = pin_sync_reg[5] & pin_sync_reg[4];
    always_ff @(posedge clk) begin
        if (!nrst) begin
            hold_cnt_reg  <= 2'd0;
            boot_ok_reg   <= 1'b0;
            boot_done_reg <= 1'b0;
        end else if (!boot_done_reg) begin
            if (!entry_ok) begin
                boot_done_reg <= 1'b1;
            end else if (hold_cnt_reg == 2'(`BOOT_HOLD_CYCLES)) begin
                boot_ok_reg   <= 1'b1;
                boot_done_reg <= 1'b1;
            end else begin
                hold_cnt_reg <= hold_cnt_reg + 2'd1;
            end
        end
    end

    // Mode choice from the select pins once entry is confirmed.
    function automatic boot_mode_e pick_mode(input mode_pins_s p, input logic sec);
        if (!p.pin4) begin
            if (!p.pin1 && !p.pin2) return MODE_CHECK;
            if (p.pin1 && !p.pin2 && !p.pin3) return MODE_PARPROG;
            if (p.pin1 && !p.pin2 && p.pin3) return MODE_SERIAL;
            return MODE_NONE;
        end
        if (!sec) return MODE_NONE;
        return p.pin3 ? MODE_SERBOOT : MODE_RAMLOAD;
    endfunction

    always_ff @(posedge clk) begin
        if (!nrst) begin
            boot_mode <= MODE_NONE;
        end else if (!boot_done_reg && entry_ok &&
                     hold_cnt_reg == 2'(`BOOT_HOLD_CYCLES)) begin
            boot_mode <= pick_mode(mp, secure_eff_reg);
        end
    end
    assign nonuser_allowed = secure_eff_reg;

    // Upper region guard; bootstrap lifts it.
    logic upper_hit;
    assign upper_hit = cpu_ee_addr >= 16'(`EE_BASE + `LOWER_REGION_BYTES);
    assign ee_write_allowed =
        !upper_hit || protect_eff_reg || boot_mode != MODE_NONE;

    // Sequencer registers.
    seq_e       state_reg;
    logic [15:0] ptr_reg;
    logic [31:0] tmr_reg;
    logic [2:0]  byte_cnt_reg;
    logic [7:0]  buf_reg [8];
    logic        verify_ee_reg;
    logic        ee_phase_reg;
    logic        blink_reg;
    logic [31:0] blink_cnt_reg;
    logic        in_eprom;
    assign in_eprom = ptr_reg >= 16'(EPROM_LO) && ptr_reg <= 16'(EPROM_HI);
    assign clr_secure = state_reg == S_CLRSEC;

    // Main loader sequence.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg          <= S_IDLE;
            ptr_reg            <= 16'h0000;
            tmr_reg            <= 32'd0;
            byte_cnt_reg       <= 3'd0;
            ee_phase_reg       <= 1'b0;
            verify_ee_reg      <= 1'b0;
            compare_output_one <= 1'b0;
            led_red            <= 1'b0;
            led_green          <= 1'b0;
            handshake_line_a   <= 1'b0;
            for (int i = 0; i < 8; i++) buf_reg[i] <= 8'h00;
        end else begin
            case (state_reg)
                S_IDLE: begin
                    if (boot_mode != MODE_NONE && boot_mode != MODE_RAMLOAD) begin
                        state_reg <= S_COPY;
                    end
                end
                S_COPY: begin
                    compare_output_one <= 1'b1;
                    ptr_reg            <= 16'(EPROM_LO);
                    state_reg          <= (boot_mode == MODE_SERBOOT) ? S_COPY : S_CHECK;
                end
                S_CHECK: begin
                    if (mem_rdata != 8'h00) begin
                        led_red   <= 1'b1;
                        state_reg <= S_FAIL;
                    end else if (ptr_reg == 16'(EPROM_HI)) begin
                        led_green <= 1'b1;
                        state_reg <= S_WAIT1;
                    end else begin
                        ptr_reg <= ptr_reg + 16'd1;
                    end
                end
                S_WAIT1: begin
                    if (boot_mode != MODE_CHECK && mp.pin1) begin
                        tmr_reg   <= 32'(ERASE_CYCLES);
                        state_reg <= S_ERASE;
                    end
                end
                S_ERASE: begin
                    if (tmr_reg == 32'd1) begin
                        ptr_reg   <= `EE_BASE;
                        state_reg <= S_ECHK;
                    end else begin
                        tmr_reg <= tmr_reg - 32'd1;
                    end
                end
                S_ECHK: begin
                    if (mem_rdata != 8'hff) begin
                        led_red   <= 1'b1;
                        tmr_reg   <= 32'(ERASE_CYCLES);
                        state_reg <= S_ERASE;
                    end else if (ptr_reg == 16'(`EE_BASE + `EE_BYTES - 1)) begin
                        led_red   <= 1'b0;
                        state_reg <= S_CLRSEC;
                    end else begin
                        ptr_reg <= ptr_reg + 16'd1;
                    end
                end
                S_CLRSEC: begin
                    ptr_reg      <= `EE_BASE;
                    ee_phase_reg <= 1'b1;
                    state_reg    <= (boot_mode == MODE_PARPROG && !mp.pin2) ? S_REQ : S_DONE;
                end
                S_REQ: begin
                    handshake_line_a <= !ack_s;
                    if (handshake_line_a && ack_s) begin
                        handshake_line_a      <= 1'b0;
                        buf_reg[byte_cnt_reg] <= porta_sync_reg;
                        byte_cnt_reg          <= byte_cnt_reg + 3'd1;
                        if (ee_phase_reg || byte_cnt_reg == 3'd7) begin
                            tmr_reg   <= 32'(PROG_CYCLES);
                            state_reg <= S_PROG;
                        end else begin
                            ptr_reg <= ptr_reg + 16'd1;
                        end
                    end
                end
                S_PROG: begin
                    led_green <= blink_reg;
                    if (tmr_reg == 32'd1) begin
                        byte_cnt_reg <= 3'd0;
                        if (ee_phase_reg && ptr_reg == 16'(`EE_BASE + `EE_BYTES - 1)) begin
                            ee_phase_reg <= 1'b0;
                            ptr_reg      <= 16'(EPROM_LO);
                        end else if (!ee_phase_reg && ptr_reg == 16'(EPROM_HI)) begin
                            ptr_reg       <= `EE_BASE;
                            verify_ee_reg <= 1'b1;
                            state_reg     <= S_VREQ;
                        end else begin
                            ptr_reg <= ptr_reg + 16'd1;
                        end
                        if (!(!ee_phase_reg && ptr_reg == 16'(EPROM_HI))) begin
                            state_reg <= S_REQ;
                        end
                    end else begin
                        tmr_reg <= tmr_reg - 32'd1;
                    end
                end
                S_VREQ: begin
                    handshake_line_a <= !ack_s;
                    if (handshake_line_a && ack_s) begin
                        handshake_line_a <= 1'b0;
                        if (porta_sync_reg != mem_rdata) begin
                            led_red   <= 1'b1;
                            led_green <= 1'b0;
                            state_reg <= S_FAIL;
                        end else if (verify_ee_reg &&
                                     ptr_reg == 16'(`EE_BASE + `EE_BYTES - 1)) begin
                            verify_ee_reg <= 1'b0;
                            ptr_reg       <= 16'(EPROM_LO);
                        end else if (!verify_ee_reg && ptr_reg == 16'(EPROM_HI)) begin
                            state_reg <= S_DONE;
                        end else begin
                            ptr_reg <= ptr_reg + 16'd1;
                        end
                    end
                end
                S_DONE: led_green <= 1'b1;
                S_FAIL: state_reg <= S_FAIL;
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // Green blink while programming, about 3 Hz.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            blink_cnt_reg <= 32'd0;
            blink_reg     <= 1'b1;
        end else if (blink_cnt_reg >= 32'(BLINK_CYCLES - 1)) begin
            blink_cnt_reg <= 32'd0;
            blink_reg     <= ~blink_reg;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + 32'd1;
        end
    end

    // Memory pins and the address output.
    logic programming;
    assign programming = state_reg == S_PROG;
    logic [2:0] slot;   // Eprom pulses write all eight slots in their last eight cycles.
    assign slot        = ee_phase_reg ? 3'd0 : tmr_reg[2:0] - 3'd1;
    assign mem_addr    = (programming && !ee_phase_reg) ? {ptr_reg[15:3], slot} : ptr_reg;
    assign mem_wdata   = buf_reg[slot];
    assign mem_wr      = programming && (ee_phase_reg ? tmr_reg == 32'd1 :
                         in_eprom && tmr_reg <= 32'd8);
    assign mem_erase   = state_reg == S_ERASE;
    assign load_addr   = ptr_reg[13:0];
endmodule // nvm_loader

// [nvm_loader_monitor.sv]
/* Port assertions for the loader block.
   Assumes one clock domain; the bind below attaches it to every instance. */
`timescale 1ns/1ns
module nvm_loader_monitor import nvm_loader_pkg::*; (
    // Clock and reset.
    input wire logic        clk,
    input wire logic        nrst,
    // Register port and array permission.
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    input wire logic [15:0] cpu_ee_addr,
    input wire logic        ee_write_allowed,
    // Mode and status.
    input wire boot_mode_e  boot_mode,
    input wire logic        nonuser_allowed,
    input wire logic        compare_output_one,
    // Loader handshake.
    input wire load_addr_s  load_addr,
    input wire logic        handshake_line_a,
    input wire logic        handshake_line_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    logic in_lower;  // Query falls in the part that is never protected.
    logic in_array;  // Query falls anywhere in the array.
    assign in_lower = cpu_ee_addr inside {[16'h0100:16'h011f]};
    assign in_array = cpu_ee_addr inside {[16'h0100:16'h01ff]};

    // Read data is driven only in the cycle after a read strobe.
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data not idle");
    a_lower_open: assert property (in_lower |-> ee_write_allowed)
        else $error("lower array write refused");
    a_boot_unprot: assert property (boot_mode != MODE_NONE && in_array |-> ee_write_allowed)
        else $error("protection active in bootstrap");
    // The secure copy only loads while reset is applied.
    a_secure_hold: assert property ($past(nrst) |-> $stable(nonuser_allowed))
        else $error("secure state changed outside reset");
    a_mode_held: assert property ($past(boot_mode) != MODE_NONE |-> $stable(boot_mode))
        else $error("boot mode changed after entry");
    a_secure_refuse: assert property (!nonuser_allowed |-> boot_mode != MODE_RAMLOAD && boot_mode != MODE_SERBOOT)
        else $error("locked part entered loader");
    a_ram_no_cmp: assert property (boot_mode == MODE_RAMLOAD |-> !compare_output_one)
        else $error("compare output raised in ram load");
    a_single_quiet: assert property (boot_mode == MODE_NONE |-> !compare_output_one)
        else $error("compare output raised in single chip");
    // A byte is taken only after the acknowledge has crossed the synchroniser.
    a_ack_first: assert property ($fell(handshake_line_a) |-> $past(handshake_line_b, 2) && $past(handshake_line_b))
        else $error("request dropped before acknowledge");
    a_addr_steady: assert property (handshake_line_a && $past(handshake_line_a) |-> $stable(load_addr))
        else $error("address moved during request");
endmodule // nvm_loader_monitor

bind nvm_loader nvm_loader_monitor u_monitor (.clk(clk), .nrst(nrst), .rd(rd), .rdata(rdata),
    .cpu_ee_addr(cpu_ee_addr), .ee_write_allowed(ee_write_allowed), .boot_mode(boot_mode),
    .nonuser_allowed(nonuser_allowed), .compare_output_one(compare_output_one),
    .load_addr(load_addr), .handshake_line_a(handshake_line_a),
    .handshake_line_b(handshake_line_b));

// [parallel_source.sv]
/* Model of the external parallel data source.
   Assumes the loader raises a request and waits for the acknowledge. */
`timescale 1ns/1ns
module parallel_source import nvm_loader_pkg::*; (
    // Clock.
    input  wire logic       clk,
    // Loader side.
    input  wire load_addr_s load_addr,
    input  wire logic       handshake_line_a,
    output logic            handshake_line_b,
    output logic [7:0]      port_a
);
    logic [13:0] a;         // Flat address from the three pin groups.
    logic [2:0]  wait_cnt;  // Cycles spent before answering.
    assign a = load_addr;

    // Image: erased eeprom but one byte, patterned eprom.
    function automatic logic [7:0] src_byte(input logic [13:0] x);
        if (x >= 14'h0100 && x < 14'h0200) begin
            return (x == 14'h0105) ? 8'h3c : 8'hff;
        end
        return x[7:0] ^ 8'ha5;
    endfunction

    initial begin
        handshake_line_b = 1'b0;
        port_a = 8'h00;
        wait_cnt = 3'h0;
    end

    // Odd addresses answer slowly.
    always @(posedge clk) begin
        if (handshake_line_a && !handshake_line_b) begin
            wait_cnt <= wait_cnt + 3'h1;
            if (wait_cnt >= (a[0] ? 3'h4 : 3'h0)) begin
                port_a <= src_byte(a);
                handshake_line_b <= 1'b1;
                wait_cnt <= 3'h0;
            end
        end else if (!handshake_line_a && handshake_line_b) begin
            // Released data is scrambled so that a late sample shows.
            handshake_line_b <= 1'b0;
            port_a <= ~port_a;
        end
    end
endmodule // parallel_source

// [tb.sv]
/* Self-checking bench for the loader block.
   Assumes the source model and a byte array model around the block. */
`timescale 1ns/1ns
module tb import nvm_loader_pkg::*;;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic        irq_high_volt = 1'b0;
    logic        capture_input_one = 1'b0;
    logic [3:0]  mode_pins = 4'h0;
    logic [15:0] mem_addr;
    logic [7:0]  mem_wdata;
    logic        mem_wr;
    logic        mem_erase;
    logic [7:0]  mem_rdata;
    logic [15:0] cpu_ee_addr = 16'h0120;  // Upper part.
    logic        ee_write_allowed;
    logic [7:0]  port_a;
    load_addr_s  load_addr;
    logic        handshake_line_a;
    logic        handshake_line_b;
    logic        compare_output_one;
    logic        led_red;
    logic        led_green;
    logic        nonuser_allowed;
    boot_mode_e  boot_mode;
    logic [7:0]  mem [16384];   // Eprom and eeprom arrays.
    int          err_total = 0;
    int          n_tests = 0;
    int          green_rises = 0;  // Green lamp rises.
    logic        green_q = 1'b0;

    // Rows: high voltage, pins, mode, compare output, write allowed, red, green.
    localparam logic [14:0] ROWS [5] = '{
        {1'b1, 4'h0, MODE_CHECK, 4'b1110},
        {1'b1, 4'h8, MODE_RAMLOAD, 4'b0100},
        {1'b1, 4'hc, MODE_SERBOOT, 4'b1100},
        {1'b0, 4'h0, MODE_NONE, 4'b0000},
        {1'b1, 4'h5, MODE_SERIAL, 4'b1101}};

    always #5 clk = ~clk;

    nvm_loader #(.ERASE_CYCLES(10), .PROG_CYCLES(10), .BLINK_CYCLES(10),
        .EPROM_LO(16'h0300), .EPROM_HI(16'h030f)) dut (.clk, .nrst, .addr, .wdata, .wr,
        .rd, .rdata, .irq_high_volt, .capture_input_one, .mode_pins, .mem_addr, .mem_wdata,
        .mem_wr, .mem_erase, .mem_rdata, .cpu_ee_addr, .ee_write_allowed, .port_a,
        .load_addr, .handshake_line_a, .handshake_line_b, .compare_output_one, .led_red,
        .led_green, .nonuser_allowed, .boot_mode);

    parallel_source src (.clk, .load_addr, .handshake_line_a, .handshake_line_b, .port_a);

    // Array model: reads in the same cycle, erase sets the eeprom to ff.
    assign mem_rdata = mem[mem_addr[13:0]];
    always @(posedge clk) begin
        if (mem_erase) begin
            for (int k = 16'h0100; k < 16'h0200; k++) begin
                mem[k] <= 8'hff;
            end
        end else if (mem_wr) begin
            mem[mem_addr[13:0]] <= mem_wdata;
        end
        green_q <= led_green;
        if (led_green && !green_q) begin
            green_rises++;
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data is looked at only in the cycle after the strobe.
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk("rdata", {8'h00, exp}, {8'h00, rdata});
    endtask

    // Entry pins stay held across the reset release and hold time.
    task automatic boot(input logic hv, input logic [3:0] pins);
        @(posedge clk);
        nrst <= 1'b0;
        irq_high_volt <= hv;
        capture_input_one <= hv;
        mode_pins <= pins;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // Waits, bounded, until the loader has talked and gone quiet.
    task automatic wait_idle();
        int  idle;
        bit  seen;
        idle = 0;
        seen = 1'b0;
        for (int k = 0; k < 40000 && !(seen && idle > 400); k++) begin
            @(posedge clk);
            seen = seen | handshake_line_a;
            idle = handshake_line_a ? 0 : idle + 1;
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        // Eprom blank but for one stray byte; eeprom needs an erase.
        for (int k = 0; k < 16384; k++) begin
            mem[k] = (k >= 16'h0100 && k < 16'h0200) ? 8'h55 : 8'h00;
        end
        mem[16'h0307] = 8'h01;
        boot(1'b0, 4'h0);
        rd_chk(16'h0100, 8'h03);
        wr_reg(16'h0100, 8'h01);
        rd_chk(16'h0100, 8'h03);
        wr_reg(16'h0007, 8'h05);
        rd_chk(16'h0007, 8'h00);
        wr_reg(16'h0007, 8'h02);
        wr_reg(16'h0100, 8'h01);
        rd_chk(16'h0100, 8'h01);
        rd_chk(16'h0055, 8'h00);
        chk("write_allowed", 16'h1, {15'h0, ee_write_allowed});
        boot(1'b0, 4'h0);
        rd_chk(16'h0100, 8'h01);
        rd_chk(16'h0007, 8'h00);
        chk("write_allowed", 16'h0, {15'h0, ee_write_allowed});
        @(posedge clk);
        cpu_ee_addr <= 16'h011f;
        @(posedge clk);
        #1 chk("write_allowed", 16'h1, {15'h0, ee_write_allowed});
        @(posedge clk);
        cpu_ee_addr <= 16'h0120;
        // Mode table; the stray byte goes after the check row.
        foreach (ROWS[i]) begin
            boot(ROWS[i][14], ROWS[i][13:10]);
            repeat (2000) @(posedge clk);
            chk("boot_mode", {10'h0, ROWS[i][9:4]}, {10'h0, boot_mode});
            chk("compare_one", {15'h0, ROWS[i][3]}, {15'h0, compare_output_one});
            chk("write_allowed", {15'h0, ROWS[i][2]}, {15'h0, ee_write_allowed});
            chk("leds", {14'h0, ROWS[i][1:0]}, {14'h0, led_red, led_green});
            mem[16'h0307] = 8'h00;
        end
        chk("nonuser", 16'h1, {15'h0, nonuser_allowed});
        // Full parallel program and verify.
        boot(1'b1, 4'h1);
        green_rises = 0;
        chk("nonuser", 16'h0, {15'h0, nonuser_allowed});
        wait_idle();
        chk("leds", 16'h1, {14'h0, led_red, led_green});
        chk("blinks", 16'h1, {15'h0, green_rises > 3});
        for (int k = 0; k < 16; k++) begin
            chk("eprom", {8'h00, 8'(k) ^ 8'ha5}, {8'h00, mem[16'h0300 + k]});
        end
        chk("eeprom", 16'h3c, {8'h00, mem[16'h0105]});
        // A locked part must not enter the ram loader.
        boot(1'b1, 4'h8);
        repeat (50) @(posedge clk);
        chk("boot_mode", {10'h0, MODE_NONE}, {10'h0, boot_mode});
        chk("nonuser", 16'h0, {15'h0, nonuser_allowed});
        give_verdict();
    end

    // Cuts a hang short; the run needs under half this span.
    initial begin
        #800000;
        err_total++;
        give_verdict();
    end
endmodule // tb
